// ### rtl/bcce_exec.sv
// Operation
// - Zero branch opcode E0 with signed byte offset, taken only when zero flag set.
// - Taken zero branch loads counter with next address plus twice the offset.
// - Zero branch takes one cycle, or two when taken with idle second cycle.
// - Call pushes counter plus four and loads 20-bit literal into counter bits 20:1.
// - Call with save flag copies working, flags and bank registers to shadows.
// - Clear-file writes zero to addressed register and sets zero flag.
// - Access bit zero selects access bank, one selects bank register bank.
// - Extended set with access bit zero and address up to 5F uses indexed offset.
// - Clear-watchdog pulses WATCHDOG_CLEAR, sets timeout and powerdown flags.
// - Complement inverts register into working or file, updates negative and zero.
// - Compare-equal skips next instruction when equal, flags untouched.
// - Compare-greater skips when register exceeds working register unsigned, flags untouched.
// - A skip discards the fetched instruction and runs an idle cycle instead.
// - Compare takes one cycle, two with skip, three when skipping two words.
`timescale 1ns/10ps
`default_nettype none
module bcce_exec
   import bcce_pkg::*;
#(
   parameter int STACK_DEPTH = 32
) (
   input wire logic SYS_CLK,
   input wire logic RST,
   input wire logic [15:0] PROG_WORD,
   output logic [20:0] PC_OUT,
   output logic [11:0] DM_ADDR,
   input wire logic [7:0] DM_RD_DATA,
   output logic [7:0] DM_WR_DATA,
   output logic DM_WE,
   input wire logic EXT_SET_EN,
   input wire logic [11:0] INDEX_BASE,
   input wire logic LOAD_STB,
   input wire logic [7:0] LOAD_W,
   input wire logic [3:0] LOAD_BANK,
   input wire logic [4:0] LOAD_STATUS,
   output logic [7:0] WORKING_REGISTER,
   output logic [3:0] BANK_SELECT_REG,
   output logic [4:0] STATUS_FLAGS,
   output logic TIMEOUT_FLAG,
   output logic POWERDOWN_FLAG,
   output logic WATCHDOG_CLEAR,
   output logic [7:0] WORKING_SHADOW,
   output logic [4:0] FLAGS_SHADOW,
   output logic [3:0] BANK_SELECT_SHADOW,
   output logic [20:0] RETURN_STACK_TOP,
   output logic [4:0] STACK_PTR,
   output logic [1:0] PHASE,
   output logic CYCLE_IDLE
);

   // ---------------------------------------------------------------
   // Decode helpers
   // ---------------------------------------------------------------
   function automatic logic op_is(input logic [15:0] w, input logic [15:0] op,
                                  input logic [15:0] mk);
      op_is = ((w & mk) == op);
   endfunction

   function automatic logic two_word(input logic [15:0] w);
      two_word = op_is(w, OP_CALL, MK_CALL) || op_is(w, OP_GOTO, MK_BRZ) ||
                 op_is(w, OP_MOVE2, MK_TOP4);
   endfunction

   // ---------------------------------------------------------------
   // State
   // ---------------------------------------------------------------
   bcce_mode_e mode_q, mode_d;
   logic [1:0] ph_q, ph_d;
   logic [15:0] ir_q, ir_d;
   logic [20:0] pc_q, pc_d;
   logic [11:0] addr_q, addr_d;
   logic [7:0] fdata_q, fdata_d;
   logic [7:0] res_q, res_d;
   logic skip_q, skip_d;
   logic [7:0] w_q, w_d;
   logic [3:0] bank_q, bank_d;
   logic [4:0] st_q, st_d;
   logic tmo_q, tmo_d;
   logic pwd_q, pwd_d;
   logic [7:0] wsh_q, wsh_d;
   logic [4:0] sts_q, sts_d;
   logic [3:0] banksh_q, banksh_d;
   logic [4:0] sp_q, sp_d;
   logic stk_we;
   logic [20:0] stk_wdata;

   logic ex, q4;
   logic dec_brz, dec_call, dec_clrfl, dec_wdclr, dec_cplf, dec_cpeq, dec_cpgt;
   logic brz_take;
   logic [20:0] brz_target;
   logic [7:0] fsel;

   assign ex = (mode_q == MODE_EXEC);
   assign q4 = (ph_q == PH_Q4);
   assign fsel = ir_q[7:0];
   assign dec_brz = op_is(ir_q, OP_BRZ, MK_BRZ);
   assign dec_call = op_is(ir_q, OP_CALL, MK_CALL);
   assign dec_clrfl = op_is(ir_q, OP_CLRFL, MK_FA);
   assign dec_wdclr = op_is(ir_q, OP_WDCLR, MK_ALL);
   assign dec_cplf = op_is(ir_q, OP_CPLF, MK_FDA);
   assign dec_cpeq = op_is(ir_q, OP_CPEQ, MK_FA);
   assign dec_cpgt = op_is(ir_q, OP_CPGT, MK_FA);
   assign brz_take = dec_brz && st_q[ST_Z];
   // The counter already points past the branch, so only twice the offset is added.
   assign brz_target = pc_q + {{12{fsel[7]}}, fsel, 1'b0};

   // ---------------------------------------------------------------
   // Next state
   // ---------------------------------------------------------------
   always_comb begin
      mode_d = mode_q;
      ph_d = ph_q + 2'h1;
      ir_d = ir_q;
      pc_d = pc_q;
      addr_d = addr_q;
      fdata_d = fdata_q;
      res_d = res_q;
      skip_d = skip_q;
      w_d = w_q;
      bank_d = bank_q;
      st_d = st_q;
      tmo_d = tmo_q;
      pwd_d = pwd_q;
      wsh_d = wsh_q;
      sts_d = sts_q;
      banksh_d = banksh_q;
      sp_d = sp_q;
      stk_we = 1'b0;
      stk_wdata = pc_q + PC_STEP;
      DM_WE = 1'b0;
      WATCHDOG_CLEAR = 1'b0;
      if (LOAD_STB) begin
         w_d = LOAD_W;
         bank_d = LOAD_BANK;
         st_d = LOAD_STATUS;
      end
      case (ph_q)
         PH_Q1: begin
            if (!ir_q[BIT_A]) begin
               if (EXT_SET_EN && fsel <= INDEX_LIMIT) begin
                  addr_d = INDEX_BASE + {4'h0, fsel};
               end else if (fsel < ACCESS_SPLIT) begin
                  addr_d = {ACCESS_LO_BANK, fsel};
               end else begin
                  addr_d = {ACCESS_HI_BANK, fsel};
               end
            end else begin
               addr_d = {bank_q, fsel};
            end
         end
         PH_Q2: begin
            fdata_d = DM_RD_DATA;
         end
         PH_Q3: begin
            res_d = dec_cplf ? ~fdata_q : BYTE_ZERO;
            skip_d = (dec_cpeq && fdata_q == w_q) ||
                     (dec_cpgt && fdata_q > w_q);
         end
         PH_Q4: begin
            case (mode_q)
               MODE_EXEC: begin
                  ir_d = PROG_WORD;
                  pc_d = pc_q + PC_STEP;
                  if (brz_take) begin
                     pc_d = brz_target;
                     ir_d = OP_NOP;
                     mode_d = MODE_FLUSH;
                  end
                  if (dec_call) begin
                     stk_we = 1'b1;
                     sp_d = sp_q + SP_ONE;
                     pc_d = {PROG_WORD[11:0], fsel, 1'b0};
                     ir_d = OP_NOP;
                     mode_d = MODE_FLUSH;
                     if (ir_q[BIT_S]) begin
                        wsh_d = w_q;
                        sts_d = st_q;
                        banksh_d = bank_q;
                     end
                  end
                  if (dec_clrfl) begin
                     DM_WE = 1'b1;
                     st_d[ST_Z] = 1'b1;
                  end
                  if (dec_cplf) begin
                     if (ir_q[BIT_D]) begin
                        DM_WE = 1'b1;
                     end else begin
                        w_d = res_q;
                     end
                     st_d[ST_N] = res_q[7];
                     st_d[ST_Z] = (res_q == BYTE_ZERO);
                  end
                  if (dec_wdclr) begin
                     WATCHDOG_CLEAR = 1'b1;
                     tmo_d = 1'b1;
                     pwd_d = 1'b1;
                  end
                  if ((dec_cpeq || dec_cpgt) && skip_q) begin
                     // The fetched word is dropped; a two-word one costs one more cycle.
                     ir_d = OP_NOP;
                     mode_d = two_word(PROG_WORD) ? MODE_SKIP2 : MODE_FLUSH;
                  end
               end
               MODE_SKIP2: begin
                  pc_d = pc_q + PC_STEP;
                  mode_d = MODE_FLUSH;
               end
               default: begin
                  ir_d = PROG_WORD;
                  pc_d = pc_q + PC_STEP;
                  mode_d = MODE_EXEC;
               end
            endcase
            skip_d = 1'b0;
         end
         default: begin
            ph_d = PH_Q1;
         end
      endcase
      if (!ex) begin
         DM_WE = 1'b0;
         WATCHDOG_CLEAR = 1'b0;
         stk_we = 1'b0;
      end
   end

   always_ff @(posedge SYS_CLK or posedge RST) begin
      if (RST) begin
         mode_q <= MODE_EXEC;
         ph_q <= PH_Q1;
         ir_q <= OP_NOP;
         pc_q <= PC_RESET;
         addr_q <= '0;
         fdata_q <= BYTE_ZERO;
         res_q <= BYTE_ZERO;
         skip_q <= 1'b0;
         w_q <= BYTE_ZERO;
         bank_q <= '0;
         st_q <= STATUS_RESET;
         tmo_q <= 1'b1;
         pwd_q <= 1'b1;
         wsh_q <= BYTE_ZERO;
         sts_q <= STATUS_RESET;
         banksh_q <= '0;
         sp_q <= '0;
      end else begin
         mode_q <= mode_d;
         ph_q <= ph_d;
         ir_q <= ir_d;
         pc_q <= pc_d;
         addr_q <= addr_d;
         fdata_q <= fdata_d;
         res_q <= res_d;
         skip_q <= skip_d;
         w_q <= w_d;
         bank_q <= bank_d;
         st_q <= st_d;
         tmo_q <= tmo_d;
         pwd_q <= pwd_d;
         wsh_q <= wsh_d;
         sts_q <= sts_d;
         banksh_q <= banksh_d;
         sp_q <= sp_d;
      end
   end

   // ---------------------------------------------------------------
   // Return stack
   // ---------------------------------------------------------------
   bcce_stack_mem #(.DEPTH(STACK_DEPTH), .AW(5), .DW(21)) u_stack (
      .clk(SYS_CLK),
      .rst(RST),
      .we(stk_we),
      .waddr(sp_d),
      .wdata(stk_wdata),
      .raddr(sp_q),
      .rdata(RETURN_STACK_TOP)
   );

   assign PC_OUT = pc_q;
   assign DM_ADDR = addr_q;
   assign DM_WR_DATA = res_q;
   assign WORKING_REGISTER = w_q;
   assign BANK_SELECT_REG = bank_q;
   assign STATUS_FLAGS = st_q;
   assign TIMEOUT_FLAG = tmo_q;
   assign POWERDOWN_FLAG = pwd_q;
   assign WORKING_SHADOW = wsh_q;
   assign FLAGS_SHADOW = sts_q;
   assign BANK_SELECT_SHADOW = banksh_q;
   assign STACK_PTR = sp_q;
   assign PHASE = ph_q;
   assign CYCLE_IDLE = !ex;

   // ---------------------------------------------------------------
   // Checks
   // ---------------------------------------------------------------
   default clocking cb @(posedge SYS_CLK); endclocking
   default disable iff (RST);

   logic at_q4x;
   assign at_q4x = q4 && ex && !LOAD_STB;

   sequence s_idle_cycle;
      (mode_q == MODE_FLUSH) [*4] ##1 (mode_q == MODE_EXEC);
   endsequence

   a_brz_target_pc: assert property (at_q4x && brz_take |=> pc_q == $past(brz_target))
      else $error("taken zero branch loaded wrong counter");
   a_brz_idle_cycle: assert property (at_q4x && brz_take |=> s_idle_cycle)
      else $error("taken zero branch idle cycle wrong");
   a_brz_not_taken: assert property (at_q4x && dec_brz && !st_q[ST_Z]
      |=> mode_q == MODE_EXEC && pc_q == $past(pc_q) + PC_STEP)
      else $error("untaken zero branch did not fall through");
   a_call_push_pc: assert property (at_q4x && dec_call
      |=> sp_q == $past(sp_q) + SP_ONE && pc_q[20:1] == {$past(PROG_WORD[11:0]),
      $past(ir_q[7:0])} ##2 RETURN_STACK_TOP == $past(pc_q, 3) + PC_STEP)
      else $error("call push or target wrong");
   a_call_shadow_save: assert property (at_q4x && dec_call && ir_q[BIT_S]
      |=> wsh_q == $past(w_q) && sts_q == $past(st_q) && banksh_q == $past(bank_q))
      else $error("call did not save shadows");
   a_call_shadow_keep: assert property (at_q4x && dec_call && !ir_q[BIT_S]
      |=> $stable(wsh_q) && $stable(sts_q) && $stable(banksh_q))
      else $error("call changed shadows without save flag");
   a_call_idle: assert property (at_q4x && dec_call |=> s_idle_cycle)
      else $error("call second cycle not idle");
   a_clrfl_write_zero: assert property (at_q4x && dec_clrfl
      |-> DM_WE && DM_WR_DATA == BYTE_ZERO ##1 st_q[ST_Z])
      else $error("clear file wrong");
   a_bank_select: assert property (ph_q == PH_Q1 && ir_q[BIT_A]
      |=> DM_ADDR == {$past(bank_q), $past(fsel)})
      else $error("banked address wrong");
   a_index_mode: assert property (ph_q == PH_Q1 && !ir_q[BIT_A] && EXT_SET_EN &&
      fsel <= INDEX_LIMIT |=> DM_ADDR == $past(INDEX_BASE) + {4'h0, $past(fsel)})
      else $error("indexed offset address wrong");
   a_wdclr_flags: assert property (at_q4x && dec_wdclr
      |-> WATCHDOG_CLEAR ##1 TIMEOUT_FLAG && POWERDOWN_FLAG)
      else $error("clear watchdog wrong");
   a_cplf_to_w: assert property (ph_q == PH_Q3 && ex && dec_cplf && !ir_q[BIT_D]
      && !LOAD_STB ##1 !LOAD_STB |=> w_q == ~$past(fdata_q, 2))
      else $error("complement result wrong");
   a_cmp_flags_keep: assert property (at_q4x && (dec_cpeq || dec_cpgt)
      |=> $stable(st_q))
      else $error("compare altered flags");
   a_skip_one_word: assert property (at_q4x && (dec_cpeq || dec_cpgt) && skip_q &&
      !two_word(PROG_WORD) |=> s_idle_cycle)
      else $error("single skip timing wrong");
   a_skip_two_word: assert property (at_q4x && (dec_cpeq || dec_cpgt) && skip_q &&
      two_word(PROG_WORD) |=> (mode_q == MODE_SKIP2) [*4] ##1 s_idle_cycle)
      else $error("double skip timing wrong");

endmodule
`default_nettype wire

// ### rtl/bcce_pkg.sv
package bcce_pkg;

   // ---------------------------------------------------------------
   // Instruction cycle phases
   // ---------------------------------------------------------------
   localparam logic [1:0] PH_Q1 = 2'h0;
   localparam logic [1:0] PH_Q2 = 2'h1;
   localparam logic [1:0] PH_Q3 = 2'h2;
   localparam logic [1:0] PH_Q4 = 2'h3;

   // ---------------------------------------------------------------
   // Opcode patterns and masks
   // ---------------------------------------------------------------
   localparam logic [15:0] OP_BRZ = 16'hE000;
   localparam logic [15:0] MK_BRZ = 16'hFF00;
   localparam logic [15:0] OP_CALL = 16'hEC00;
   localparam logic [15:0] MK_CALL = 16'hFE00;
   localparam logic [15:0] OP_CLRFL = 16'h6A00;
   localparam logic [15:0] OP_CPEQ = 16'h6200;
   localparam logic [15:0] OP_CPGT = 16'h6400;
   localparam logic [15:0] MK_FA = 16'hFE00;
   localparam logic [15:0] OP_CPLF = 16'h1C00;
   localparam logic [15:0] MK_FDA = 16'hFC00;
   localparam logic [15:0] OP_WDCLR = 16'h0004;
   localparam logic [15:0] MK_ALL = 16'hFFFF;
   localparam logic [15:0] OP_GOTO = 16'hEF00;
   localparam logic [15:0] OP_MOVE2 = 16'hC000;
   localparam logic [15:0] MK_TOP4 = 16'hF000;
   localparam logic [15:0] OP_NOP = 16'h0000;

   // ---------------------------------------------------------------
   // Field positions
   // ---------------------------------------------------------------
   localparam int BIT_A = 8;
   localparam int BIT_D = 9;
   localparam int BIT_S = 8;
   localparam int ST_Z = 2;
   localparam int ST_N = 4;

   // ---------------------------------------------------------------
   // Addressing and reset values
   // ---------------------------------------------------------------
   localparam logic [7:0] ACCESS_SPLIT = 8'h60;
   localparam logic [7:0] INDEX_LIMIT = 8'h5F;
   localparam logic [3:0] ACCESS_LO_BANK = 4'h0;
   localparam logic [3:0] ACCESS_HI_BANK = 4'hF;
   localparam logic [20:0] PC_STEP = 21'h000002;
   localparam logic [20:0] PC_RESET = 21'h000000;
   localparam logic [7:0] BYTE_ZERO = 8'h00;
   localparam logic [4:0] STATUS_RESET = 5'h00;
   localparam logic [4:0] SP_ONE = 5'h01;

   typedef enum logic [1:0] {MODE_EXEC, MODE_FLUSH, MODE_SKIP2} bcce_mode_e;

endpackage

// ### rtl/bcce_stack_mem.sv
`timescale 1ns/10ps
`default_nettype none
module bcce_stack_mem #(
   parameter int DEPTH = 32,
   parameter int AW = 5,
   parameter int DW = 21
) (
   input wire logic clk,
   input wire logic rst,
   input wire logic we,
   input wire logic [AW-1:0] waddr,
   input wire logic [DW-1:0] wdata,
   input wire logic [AW-1:0] raddr,
   output logic [DW-1:0] rdata
);

   logic [DW-1:0] mem [DEPTH];

   // The array holds no reset so it maps onto plain RAM cells.
   always_ff @(posedge clk) begin
      if (we) begin
         mem[waddr] <= wdata;
      end
   end

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         rdata <= '0;
      end else begin
         rdata <= mem[raddr];
      end
   end

endmodule
`default_nettype wire

// ### testbench/bcce_mem_model.sv
`timescale 1ns/10ps
`default_nettype none
module bcce_mem_model (
   input wire logic clk,
   input wire logic [20:0] pc,
   output logic [15:0] prog_word,
   input wire logic [11:0] dm_addr,
   output logic [7:0] dm_rd_data,
   input wire logic [7:0] dm_wr_data,
   input wire logic dm_we
);
   // ---------------------------------------------------------------
   // Program and data arrays
   // ---------------------------------------------------------------
   logic [15:0] prog [0:8191];
   logic [7:0] dm [0:4095];

   // Words sit at even byte addresses, so bit 0 of the counter is not used.
   assign prog_word = prog[pc[13:1]];
   assign dm_rd_data = dm[dm_addr];

   always @(posedge clk) begin
      if (dm_we === 1'b1) begin
         dm[dm_addr] <= dm_wr_data;
      end
   end
endmodule
`default_nettype wire

// ### testbench/branch_call_clear_compare_exec_bench.sv
`timescale 1ns/10ps
`default_nettype none
module branch_call_clear_compare_exec_bench;
   import bcce_pkg::*;
   // ---------------------------------------------------------------
   // Signals and counters
   // ---------------------------------------------------------------
   logic sys_clk = 1'b0;
   logic rst = 1'b1;
   logic ext_set_en = 1'b0;
   logic [11:0] index_base = 12'h000;
   logic load_stb = 1'b0;
   logic [7:0] load_w = 8'h00;
   logic [3:0] load_bank = 4'h0;
   logic [4:0] load_status = 5'h00;
   logic [15:0] prog_word;
   logic [20:0] pc_out, return_stack_top;
   logic [11:0] dm_addr;
   logic [7:0] dm_rd_data, dm_wr_data, working_register, working_shadow;
   logic [3:0] bank_select_reg, bank_select_shadow;
   logic [4:0] status_flags, flags_shadow, stack_ptr;
   logic [1:0] phase;
   logic dm_we, timeout_flag, powerdown_flag, watchdog_clear, cycle_idle;
   int mismatches = 0;
   int check_count = 0;
   int cycles = 0;
   int idle_n = 0;
   int wdt_n = 0;

   always #10 sys_clk = ~sys_clk;

   bcce_exec dut (.SYS_CLK(sys_clk), .RST(rst), .PROG_WORD(prog_word), .PC_OUT(pc_out),
      .DM_ADDR(dm_addr), .DM_RD_DATA(dm_rd_data), .DM_WR_DATA(dm_wr_data), .DM_WE(dm_we),
      .EXT_SET_EN(ext_set_en), .INDEX_BASE(index_base), .LOAD_STB(load_stb),
      .LOAD_W(load_w), .LOAD_BANK(load_bank), .LOAD_STATUS(load_status),
      .WORKING_REGISTER(working_register), .BANK_SELECT_REG(bank_select_reg),
      .STATUS_FLAGS(status_flags), .TIMEOUT_FLAG(timeout_flag),
      .POWERDOWN_FLAG(powerdown_flag), .WATCHDOG_CLEAR(watchdog_clear),
      .WORKING_SHADOW(working_shadow), .FLAGS_SHADOW(flags_shadow),
      .BANK_SELECT_SHADOW(bank_select_shadow), .RETURN_STACK_TOP(return_stack_top),
      .STACK_PTR(stack_ptr), .PHASE(phase), .CYCLE_IDLE(cycle_idle));

   bcce_mem_model mem (.clk(sys_clk), .pc(pc_out), .prog_word(prog_word), .dm_addr(dm_addr),
      .dm_rd_data(dm_rd_data), .dm_wr_data(dm_wr_data), .dm_we(dm_we));

   // ---------------------------------------------------------------
   // Shared tasks
   // ---------------------------------------------------------------
   task automatic tally_and_finish();
      $display("checks %0d mismatches %0d", check_count, mismatches);
      if (mismatches == 0 && check_count > 0) begin
         $display("Testbench passed");
      end else begin
         $display("Testbench failed");
      end
      $finish;
   endtask

   // A hang well beyond the few hundred cycles the scenarios need ends the run.
   always @(posedge sys_clk) begin
      cycles++;
      if (cycles == 5000) begin
         mismatches++;
         tally_and_finish();
      end
   end

   task automatic check(input string what, input logic [20:0] exp, input logic [20:0] got);
      check_count++;
      if (got !== exp) begin
         mismatches++;
         $display("mismatch %s expected %0h seen %0h", what, exp, got);
      end
   endtask

   task automatic wipe();
      foreach (mem.prog[i]) mem.prog[i] = OP_NOP;
      foreach (mem.dm[i]) mem.dm[i] = BYTE_ZERO;
   endtask

   // Loads happen in the opening NOP cycle after reset, so no instruction competes with them.
   task automatic start(input logic [4:0] st, input logic [7:0] w, input logic [3:0] bank,
                        input logic ext);
      @(posedge sys_clk);
      rst <= 1'b1;
      ext_set_en <= ext;
      index_base <= 12'h200;
      repeat (3) @(posedge sys_clk);
      rst <= 1'b0;
      @(posedge sys_clk);
      load_stb <= 1'b1;
      load_w <= w;
      load_bank <= bank;
      load_status <= st;
      @(posedge sys_clk);
      load_stb <= 1'b0;
      repeat (2) @(posedge sys_clk);
      idle_n = 0;
      wdt_n = 0;
   endtask

   task automatic run(input int n);
      repeat (4 * n) begin
         @(posedge sys_clk);
         #1;
         if (cycle_idle === 1'b1) idle_n++;
         if (watchdog_clear === 1'b1) wdt_n++;
      end
   endtask

   // ---------------------------------------------------------------
   // Scenarios
   // ---------------------------------------------------------------
   task automatic t_clear_banks();
      wipe();
      mem.dm[12'h012] = 8'hAA;
      mem.dm[12'hF80] = 8'hBB;
      mem.dm[12'h312] = 8'hCC;
      mem.dm[12'h313] = 8'hDD;
      mem.prog[0] = 16'h6A12;
      mem.prog[1] = 16'h6A80;
      mem.prog[2] = 16'h6B12;
      start(5'h00, 8'h00, 4'h3, 1'b0);
      run(5);
      check("access low", 21'h0, mem.dm[12'h012]);
      check("access high", 21'h0, mem.dm[12'hF80]);
      check("banked", 21'h0, mem.dm[12'h312]);
      check("neighbour", 21'hDD, mem.dm[12'h313]);
      check("zero flag", 21'h1, status_flags[ST_Z]);
      check("idle", 21'h0, idle_n);
   endtask

   task automatic t_indexed();
      wipe();
      mem.dm[12'h210] = 8'hAA;
      mem.dm[12'h010] = 8'hBB;
      mem.dm[12'hF60] = 8'hCC;
      mem.prog[0] = 16'h6A10;
      mem.prog[1] = 16'h6A60;
      start(5'h00, 8'h00, 4'h0, 1'b1);
      run(4);
      check("indexed", 21'h0, mem.dm[12'h210]);
      check("direct kept", 21'hBB, mem.dm[12'h010]);
      check("above limit", 21'h0, mem.dm[12'hF60]);
   endtask

   task automatic t_complement();
      wipe();
      mem.dm[12'h020] = 8'h13;
      mem.dm[12'h021] = 8'hFF;
      mem.prog[0] = 16'h1C20;
      mem.prog[1] = 16'h1E21;
      start(5'h00, 8'h00, 4'h0, 1'b0);
      run(4);
      check("complement_file_op to w", 21'hEC, working_register);
      check("complement_file_op src kept", 21'h13, mem.dm[12'h020]);
      check("complement_file_op to f", 21'h00, mem.dm[12'h021]);
      check("complement_file_op flags", 21'h04, status_flags);
   endtask

   task automatic t_watchdog();
      wipe();
      mem.prog[0] = OP_WDCLR;
      start(5'h00, 8'h00, 4'h0, 1'b0);
      run(3);
      check("wdt pulses", 21'h1, wdt_n);
      check("timeout", 21'h1, timeout_flag);
      check("powerdown", 21'h1, powerdown_flag);
      check("idle", 21'h0, idle_n);
   endtask

   // Forward hop over three words, then a backward hop that must sign-extend.
   task automatic t_branch(input logic z);
      wipe();
      mem.dm[12'h030] = 8'h55;
      mem.dm[12'h031] = 8'h55;
      mem.prog[0] = 16'hE003;
      mem.prog[1] = 16'h6A30;
      mem.prog[2] = 16'h6A31;
      mem.prog[3] = 16'h1E32;
      mem.prog[4] = 16'hE0FD;
      start({2'b00, z, 2'b00}, 8'h00, 4'h0, 1'b0);
      run(10);
      check("hopped word", z ? 21'h55 : 21'h00, mem.dm[12'h030]);
      check("back target", 21'h00, mem.dm[12'h031]);
      check("last word", 21'hFF, mem.dm[12'h032]);
      check("branch idle", z ? 21'h8 : 21'h0, idle_n);
   endtask

   task automatic t_call();
      wipe();
      mem.dm[12'h040] = 8'h77;
      mem.prog[0] = 16'hED34;
      mem.prog[1] = 16'hF012;
      mem.prog[13'h1234] = 16'h1C40;
      mem.prog[13'h1235] = 16'hEC10;
      mem.prog[13'h1236] = 16'hF000;
      start(5'h03, 8'h5A, 4'h7, 1'b0);
      run(8);
      check("target ran", 21'h88, working_register);
      check("stack ptr", 21'h2, stack_ptr);
      check("return addr", 21'h00246E, return_stack_top);
      check("w shadow", 21'h5A, working_shadow);
      check("flag shadow", 21'h03, flags_shadow);
      check("bank shadow", 21'h7, bank_select_shadow);
      check("call idle", 21'h8, idle_n);
   endtask

   task automatic t_compare();
      wipe();
      mem.dm[12'h050] = 8'h40;
      mem.dm[12'h051] = 8'h41;
      mem.dm[12'h052] = 8'h3F;
      for (int i = 0; i < 4; i++) mem.dm[12'h030 + i] = 8'h55;
      mem.prog[0] = 16'h6250;
      mem.prog[1] = 16'h6A30;
      mem.prog[2] = 16'h6251;
      mem.prog[3] = 16'h6A31;
      mem.prog[4] = 16'h6451;
      mem.prog[5] = 16'hEC20;
      mem.prog[6] = 16'hF000;
      mem.prog[7] = 16'h6452;
      mem.prog[8] = 16'h6A32;
      mem.prog[9] = 16'h6450;
      mem.prog[10] = 16'h6A33;
      start(5'h10, 8'h40, 4'h0, 1'b0);
      run(18);
      check("eq skipped", 21'h55, mem.dm[12'h030]);
      check("ne ran", 21'h00, mem.dm[12'h031]);
      check("le ran", 21'h00, mem.dm[12'h032]);
      check("eq not gt", 21'h00, mem.dm[12'h033]);
      check("call skipped", 21'h0, stack_ptr);
      check("skip idle", 21'hC, idle_n);
      check("flags kept", 21'h14, status_flags);
   endtask

   initial begin
      t_clear_banks();
      t_indexed();
      t_complement();
      t_watchdog();
      t_branch(1'b1);
      t_branch(1'b0);
      t_call();
      t_compare();
      tally_and_finish();
   end
endmodule
`default_nettype wire
